/* File: ssd_top.sv */
// serial programming word decoder of the synthesizer
//
// Behaviour
// R1: control bits 00 ref, 10 fb, 01 func, 11 init
// R2: feedback word bit 19 is the go flag
// R3: feedback bits 18..6 hold main count
// R4: feedback bits 5..1 hold swallow count
// R5: division equals modulus times main plus swallow
// R6: host keeps main >= swallow and >= 3
// R7: words arrive msb first, control bits last
// R8: reference bit 19 selects lock detector precision
// R9: host writes zeros to reference bits 18..15
// R10: reference bits 14..1 hold reference ratio
// R11: function bit 1 holds both counters at load
// R12: mode 100 with go keeps 4x until cleared
// R13: mode 101 with go times out, clears go
// R14: function bits 11..14 hold timeout count
// R15: modes three and four add further 4x
// R16: words are 21 bits in the shift register
// R17: data sampled on rising serial clock edge
// R18: timeout lasts 3 plus 4 x field ticks
// R19: init loads function latch and pulses reset
// R20: enable rising edge transfers word to latch
`include "ssd_defs.svh"

module ssd_top import ssd_pkg::*; #(
   parameter int PRESCALE = 32,
   parameter int TOTAL_W = 19
) (
   // core clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // serial link
   input wire logic link_clk,
   input wire logic ser_data,
   input wire logic ser_en,
   // phase detector comparison tick, core domain
   input wire logic pd_tick,
   // latched settings
   output ssd_fb_t fb_q,
   output ssd_ref_t ref_q,
   output logic [`SSD_DATA_W-1:0] func_q,
   output logic [TOTAL_W-1:0] div_total_q,
   // loop control
   output ssd_ctl_t ctl_q,
   output logic boost_busy_q,
   // host programming checks
   output logic fb_ratio_bad_q,
   output logic ref_test_bad_q
);

   // ----------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // ----------------------------------------------------------------------
   // link domain shift register
   // ----------------------------------------------------------------------
   // no reset here: the link clock may stand still and the contents are
   // only taken on an enable edge after a full word
   logic [`SSD_WORD_W-1:0] shift_q;

   always_ff @(posedge link_clk) begin
      shift_q <= {shift_q[`SSD_WORD_W-2:0], ser_data}; // R7 R16 R17
   end

   // ----------------------------------------------------------------------
   // enable crossing and word capture
   // ----------------------------------------------------------------------
   logic en_meta_q;
   logic en_sync_q;
   logic en_prev_q;
   logic load_q;
   logic [`SSD_WORD_W-1:0] word_q;

   // the host stops the link clock before raising enable, so the shift
   // register is quiet for the two-flop delay and is taken as a whole word
   wire logic en_rise = en_sync_q && !en_prev_q;

   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         en_meta_q <= 1'b0;
         en_sync_q <= 1'b0;
         en_prev_q <= 1'b0;
         load_q <= 1'b0;
         word_q <= '0;
      end else begin
         en_meta_q <= ser_en;
         en_sync_q <= en_meta_q;
         en_prev_q <= en_sync_q;
         load_q <= en_rise; // R20
         if (en_rise) begin
            word_q <= shift_q; // R20
         end
      end
   end

   // ----------------------------------------------------------------------
   // destination decode
   // ----------------------------------------------------------------------
   wire ssd_dest_t dest = ssd_dest_t'(word_q[`SSD_CTRL_MSB:`SSD_CTRL_LSB]);
   wire logic [`SSD_DATA_W-1:0] data = word_q[`SSD_DATA_MSB:`SSD_DATA_LSB];
   wire logic wr_ref = load_q && dest == SSD_REF; // R1
   wire logic wr_fb = load_q && dest == SSD_FB; // R1
   wire logic wr_func = load_q && dest == SSD_FUNC; // R1
   wire logic wr_init = load_q && dest == SSD_INIT; // R1
   wire ssd_fb_t fb_word = ssd_fb_t'(data); // R2 R3 R4
   wire ssd_ref_t ref_word = ssd_ref_t'(data); // R8 R10

   // ----------------------------------------------------------------------
   // boost timing
   // ----------------------------------------------------------------------
   logic init_armed_q;
   logic to_done;

   // the first feedback load after an init word repeats the reset pulse
   wire logic rst_pulse = wr_init || (wr_fb && init_armed_q); // R19
   wire logic timed = func_q[`SSD_F_BOOST_TIMED];
   wire logic to_start = wr_fb && fb_word.go && func_q[`SSD_F_BOOST_EN] && timed; // R13
   // any later feedback load or reset pulse that does not start a new timeout ends a running one
   wire logic to_abort = (rst_pulse || wr_fb) && !to_start; // R19

   ssd_timeout #(
      .CNT_W(6)
   ) u_timeout (
      .clock(clock),
      .rst_n(rst_n_q),
      .start(to_start),
      .abort(to_abort),
      .tick(pd_tick),
      .field(func_q[`SSD_F_TO_MSB:`SSD_F_TO_LSB]), // R14
      .busy_q(boost_busy_q),
      .done_q(to_done)
   );

   // ----------------------------------------------------------------------
   // latch next values
   // ----------------------------------------------------------------------
   // a new go from the host wins over a timeout ending in the same cycle
   wire logic go_d = wr_fb ? fb_word.go : // R2 R12
                     (to_done && timed) ? 1'b0 : fb_q.go; // R13
   wire ssd_fb_t fb_d = wr_fb ? {go_d, fb_word.main, fb_word.swallow} : // R3 R4
                        {go_d, fb_q.main, fb_q.swallow};
   wire logic [`SSD_DATA_W-1:0] func_d = (wr_func || wr_init) ? data : func_q; // R19
   wire logic boost_on = fb_q.go && func_q[`SSD_F_BOOST_EN];
   wire logic fb_bad = fb_word.main < `SSD_MAIN_MIN ||
                       fb_word.main < 13'(fb_word.swallow); // R6
   wire logic [TOTAL_W-1:0] total_d = TOTAL_W'(PRESCALE * fb_q.main + fb_q.swallow); // R5
   wire ssd_ctl_t ctl_d = '{
      x4: boost_on, // R12 R13
      x16: boost_on && func_q[`SSD_F_BOOST_X16], // R15
      hold: func_q[`SSD_F_HOLD] || rst_pulse, // R11
      cp_tri: func_q[`SSD_F_HOLD] || rst_pulse, // R19
      init: rst_pulse // R19
   };

   // ----------------------------------------------------------------------
   // latches and outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fb_q <= `SSD_LATCH_RST;
         ref_q <= `SSD_LATCH_RST;
         func_q <= `SSD_LATCH_RST;
         init_armed_q <= 1'b0;
         div_total_q <= '0;
         ctl_q <= '0;
         fb_ratio_bad_q <= 1'b0;
         ref_test_bad_q <= 1'b0;
      end else begin
         fb_q <= fb_d;
         func_q <= func_d;
         div_total_q <= total_d;
         ctl_q <= ctl_d;
         if (wr_ref) begin
            ref_q <= ref_word; // R8 R10
            ref_test_bad_q <= |ref_word.test; // R9
         end
         if (wr_fb) begin
            fb_ratio_bad_q <= fb_bad; // R6
         end
         if (wr_init) begin
            init_armed_q <= 1'b1;
         end else if (wr_fb) begin
            init_armed_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_load;
      @(posedge clock) disable iff (!rst_n_q)
      en_rise |=> load_q ##1 !load_q;
   endproperty
   a_load: assert property (p_load) else $error("enable edge did not give one load"); // R20

   property p_ref;
      @(posedge clock) disable iff (!rst_n_q)
      wr_ref |=> ref_q.ratio == $past(data[13:0]) && $stable(fb_q.main);
   endproperty
   a_ref: assert property (p_ref) else $error("reference ratio not latched"); // R10

   property p_precise;
      @(posedge clock) disable iff (!rst_n_q)
      wr_ref |=> ref_q.precise == $past(word_q[`SSD_DATA_MSB]);
   endproperty
   a_precise: assert property (p_precise) else $error("lock precision bit wrong"); // R8

   property p_fb;
      @(posedge clock) disable iff (!rst_n_q)
      wr_fb |=> fb_q.main == $past(word_q[19:7]) && fb_q.swallow == $past(word_q[6:2])
                && fb_q.go == $past(word_q[20]) && $stable(ref_q);
   endproperty
   a_fb: assert property (p_fb) else $error("feedback word fields wrong"); // R3

   property p_func_only;
      @(posedge clock) disable iff (!rst_n_q)
      wr_func |=> func_q == $past(data) && !ctl_q.init && $stable(fb_q.main);
   endproperty
   a_func_only: assert property (p_func_only) else $error("function load misrouted"); // R1

   property p_total;
      @(posedge clock) disable iff (!rst_n_q)
      wr_fb |-> ##2 div_total_q ==
         TOTAL_W'(PRESCALE * $past(word_q[19:7], 2) + $past(word_q[6:2], 2));
   endproperty
   a_total: assert property (p_total) else $error("division total wrong"); // R5

   property p_hold;
      @(posedge clock) disable iff (!rst_n_q)
      func_q[`SSD_F_HOLD] |=> ctl_q.hold && ctl_q.cp_tri;
   endproperty
   a_hold: assert property (p_hold) else $error("counters not held"); // R11

   property p_release;
      @(posedge clock) disable iff (!rst_n_q)
      !func_q[`SSD_F_HOLD] && !rst_pulse |=> !ctl_q.hold;
   endproperty
   a_release: assert property (p_release) else $error("counters not released"); // R11

   property p_mode1;
      @(posedge clock) disable iff (!rst_n_q)
      fb_q.go && func_q[`SSD_F_BOOST_EN] && !timed && !wr_fb && !wr_func && !wr_init
      |=> ctl_q.x4 && fb_q.go;
   endproperty
   a_mode1: assert property (p_mode1) else $error("held boost dropped"); // R12

   property p_timed_end;
      @(posedge clock) disable iff (!rst_n_q)
      to_done && timed && !wr_fb |=> !fb_q.go ##1 !ctl_q.x4;
   endproperty
   a_timed_end: assert property (p_timed_end) else $error("timed boost did not end"); // R13

   property p_x16;
      @(posedge clock) disable iff (!rst_n_q)
      ctl_q.x16 |-> ctl_q.x4 && $past(func_q[`SSD_F_BOOST_X16]);
   endproperty
   a_x16: assert property (p_x16) else $error("extra gain without boost"); // R15

   property p_init;
      @(posedge clock) disable iff (!rst_n_q)
      wr_init |=> ctl_q.init && ctl_q.cp_tri && func_q == $past(data) ##1 !ctl_q.init;
   endproperty
   a_init: assert property (p_init) else $error("init pulse missing"); // R19

   property p_init_fb;
      @(posedge clock) disable iff (!rst_n_q)
      wr_fb && init_armed_q |=> ctl_q.init && ctl_q.cp_tri;
   endproperty
   a_init_fb: assert property (p_init_fb) else $error("first feedback after init no pulse"); // R19

   property p_fb_no_pulse;
      @(posedge clock) disable iff (!rst_n_q)
      wr_fb && !init_armed_q |=> !ctl_q.init;
   endproperty
   a_fb_no_pulse: assert property (p_fb_no_pulse) else $error("stray reset pulse"); // R19

   property p_init_busy;
      @(posedge clock) disable iff (!rst_n_q)
      wr_init |=> !boost_busy_q;
   endproperty
   a_init_busy: assert property (p_init_busy) else $error("timeout survived reset pulse"); // R19

   property p_ref_flag;
      @(posedge clock) disable iff (!rst_n_q)
      wr_ref |=> ref_test_bad_q == ($past(word_q[19:16]) != 4'h0);
   endproperty
   a_ref_flag: assert property (p_ref_flag) else $error("test bit flag wrong"); // R9

endmodule : ssd_top

/* File: ssd_defs.svh */
// constants for the serial programming word decoder
`ifndef SSD_DEFS_SVH
`define SSD_DEFS_SVH

// ----------------------------------------------------------------------
// word layout: bit 0 is the last bit shifted, data bit k sits at k+1
// ----------------------------------------------------------------------
`define SSD_WORD_W 21
`define SSD_DATA_W 19
`define SSD_DATA_MSB 20
`define SSD_DATA_LSB 2
`define SSD_CTRL_MSB 1
`define SSD_CTRL_LSB 0

// ----------------------------------------------------------------------
// destination codes {dest_select_hi, dest_select_lo}
// ----------------------------------------------------------------------
`define SSD_DEST_REF 2'h0
`define SSD_DEST_FB 2'h2
`define SSD_DEST_FUNC 2'h1
`define SSD_DEST_INIT 2'h3

// ----------------------------------------------------------------------
// function latch bit positions (latch bit k-1 holds function bit k)
// ----------------------------------------------------------------------
`define SSD_F_HOLD 0
`define SSD_F_BOOST_EN 7
`define SSD_F_BOOST_X16 8
`define SSD_F_BOOST_TIMED 9
`define SSD_F_TO_MSB 13
`define SSD_F_TO_LSB 10

// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define SSD_LATCH_RST 19'h0_0000
`define SSD_MAIN_MIN 13'h0003
`define SSD_TO_BASE 3
`define SSD_TO_STEP 4

`endif

/* File: ssd_pkg.sv */
// types shared by the serial word decoder
`include "ssd_defs.svh"

package ssd_pkg;

   typedef struct packed {
      logic go;
      logic [12:0] main;
      logic [4:0] swallow;
   } ssd_fb_t;

   typedef struct packed {
      logic precise;
      logic [3:0] test;
      logic [13:0] ratio;
   } ssd_ref_t;

   typedef struct packed {
      logic x4;
      logic x16;
      logic hold;
      logic cp_tri;
      logic init;
   } ssd_ctl_t;

   typedef enum logic [1:0] {
      SSD_REF = `SSD_DEST_REF,
      SSD_FB = `SSD_DEST_FB,
      SSD_FUNC = `SSD_DEST_FUNC,
      SSD_INIT = `SSD_DEST_INIT
   } ssd_dest_t;

   function automatic logic [5:0] ssd_timeout_len(input logic [3:0] field);
      return 6'(`SSD_TO_BASE + `SSD_TO_STEP * field);
   endfunction : ssd_timeout_len

endpackage : ssd_pkg

/* File: ssd_timeout.sv */
// boost timeout counter, counts phase detector cycles
module ssd_timeout import ssd_pkg::*; #(
   parameter int CNT_W = 6
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic tick,
   input wire logic [3:0] field,
   // status
   output logic busy_q,
   output logic done_q
);

   logic [CNT_W-1:0] cnt_q;
   wire logic last = (cnt_q == CNT_W'(1));
   wire logic expire = busy_q && tick && last && !start && !abort;
   wire logic [CNT_W-1:0] cnt_d = abort ? '0 :
                                  start ? CNT_W'(ssd_timeout_len(field)) : // R18
                                  (busy_q && tick) ? cnt_q - 1'b1 : cnt_q;
   wire logic busy_d = abort ? 1'b0 : start ? 1'b1 : expire ? 1'b0 : busy_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= expire; // R14
      end
   end

   property p_len;
      @(posedge clock) disable iff (!rst_n)
      start && !abort |=> busy_q && cnt_q == CNT_W'(ssd_timeout_len($past(field)));
   endproperty
   a_len: assert property (p_len) else $error("timeout length not 3 plus 4 x field"); // R18

   property p_expire;
      @(posedge clock) disable iff (!rst_n)
      busy_q && tick && last && !start && !abort |=> done_q && !busy_q ##1 !done_q;
   endproperty
   a_expire: assert property (p_expire) else $error("timeout did not end on last tick"); // R14

   property p_hold_no_tick;
      @(posedge clock) disable iff (!rst_n)
      busy_q && !tick && !start && !abort |=> busy_q && $stable(cnt_q);
   endproperty
   a_hold_no_tick: assert property (p_hold_no_tick) else $error("timeout moved without tick"); // R18

endmodule : ssd_timeout

/* File: ssd_host_model.sv */
// host model that shifts programming words over the three-wire link
`include "ssd_defs.svh"

module ssd_host_model import ssd_pkg::*; (
   // serial link
   output logic link_clk,
   output logic ser_data,
   output logic ser_en
);
   timeunit 1ns;
   timeprecision 100ps;

   // half of the 160 ns link period
   localparam realtime HALF = 80ns;

   initial begin
      link_clk = 1'b0;
      ser_data = 1'b0;
      ser_en = 1'b0;
   end

   // -----------------------------
   // word transfer
   // -----------------------------
   // clock stands low outside frames; data turns to the inverse of the last
   // bit so a stale level is never mistaken for a held one
   task automatic send(input logic [`SSD_WORD_W-1:0] word);
      for (int i = `SSD_WORD_W - 1; i >= 0; i--) begin
         ser_data = word[i];
         #(HALF) link_clk = 1'b1;
         #(HALF) link_clk = 1'b0;
      end
      ser_data = ~word[0];
      #(HALF) ser_en = 1'b1;
      #(HALF) ser_en = 1'b0;
      #(HALF);
   endtask : send

endmodule : ssd_host_model

/* File: ssd_top_bench.sv */
// self-checking bench for the serial programming word decoder
`include "ssd_defs.svh"

module ssd_top_bench import ssd_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------
   // design under test and host
   // -----------------------------
   logic clock;
   logic arst_n;
   logic link_clk;
   logic ser_data;
   logic ser_en;
   logic pd_tick;
   ssd_fb_t fb_q;
   ssd_ref_t ref_q;
   logic [`SSD_DATA_W-1:0] func_q;
   logic [18:0] div_total_q;
   ssd_ctl_t ctl_q;
   logic boost_busy_q;
   logic fb_ratio_bad_q;
   logic ref_test_bad_q;
   int err_total = 0;
   int check_count = 0;
   int n_init;
   int n_tri;

   ssd_top #(.PRESCALE(32), .TOTAL_W(19)) uut (
      .clock(clock), .arst_n(arst_n), .link_clk(link_clk), .ser_data(ser_data),
      .ser_en(ser_en), .pd_tick(pd_tick), .fb_q(fb_q), .ref_q(ref_q), .func_q(func_q),
      .div_total_q(div_total_q), .ctl_q(ctl_q), .boost_busy_q(boost_busy_q),
      .fb_ratio_bad_q(fb_ratio_bad_q), .ref_test_bad_q(ref_test_bad_q)
   );

   ssd_host_model host (.link_clk(link_clk), .ser_data(ser_data), .ser_en(ser_en));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // -----------------------------
   // helpers
   // -----------------------------
   task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // mode is {timed, extra gain, enable}
   function automatic logic [18:0] fw(input logic [2:0] mode, input logic [3:0] to,
         input logic hold);
      return {5'h00, to, mode, 6'h00, hold};
   endfunction : fw

   // the reset pulse lasts one cycle, so it is counted while the word goes out
   task automatic put(input logic [1:0] dest, input logic [18:0] data);
      n_init = 0;
      n_tri = 0;
      fork
         host.send({data, dest});
         repeat (1000) begin
            @(negedge clock);
            n_init += (ctl_q.init === 1'b1) ? 1 : 0;
            n_tri += (ctl_q.cp_tri === 1'b1) ? 1 : 0;
         end
      join
   endtask : put

   task automatic pulse(input int n);
      repeat (n) begin
         @(negedge clock) pd_tick = 1'b1;
         @(negedge clock) pd_tick = 1'b0;
      end
   endtask : pulse

   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   initial begin
      #200us;
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      summarize();
   end

   // -----------------------------
   // tests
   // -----------------------------
   initial begin
      logic [1:0] idx;
      logic [3:0] fld;
      int len;
      arst_n = 1'b0;
      pd_tick = 1'b0;
      repeat (5) @(negedge clock);
      chk(19'(ctl_q), 19'h0_0000);
      arst_n = 1'b1;
      repeat (3) @(negedge clock);
      put(2'h0, {1'b1, 4'h0, 14'h0032});
      chk(19'(ref_q.precise), 19'h0_0001);
      chk(19'(ref_q.ratio), 19'h0_0032);
      chk(19'(ref_test_bad_q), 19'h0_0000);
      put(2'h0, {1'b0, 4'h5, 14'h0032});
      chk(19'(ref_q.test), 19'h0_0005);
      chk(19'(ref_test_bad_q), 19'h0_0001);
      $display("test reference done");
      put(2'h2, {1'b0, 13'h0094, 5'h0e});
      chk(19'(fb_q.main), 19'h0_0094);
      chk(19'(fb_q.swallow), 19'h0_000e);
      chk(div_total_q, 19'h0_128e);
      chk(19'(fb_ratio_bad_q), 19'h0_0000);
      chk(19'(ref_q.ratio), 19'h0_0032);
      put(2'h2, {1'b0, 13'h0002, 5'h01});
      chk(div_total_q, 19'h0_0041);
      chk(19'(fb_ratio_bad_q), 19'h0_0001);
      put(2'h2, {1'b0, 13'h0003, 5'h04});
      chk(19'(fb_ratio_bad_q), 19'h0_0001);
      $display("test feedback done");
      put(2'h1, fw(3'h0, 4'h0, 1'b1));
      chk(func_q, fw(3'h0, 4'h0, 1'b1));
      chk(19'(ctl_q.hold), 19'h0_0001);
      chk(19'(ctl_q.cp_tri), 19'h0_0001);
      put(2'h1, fw(3'h0, 4'h0, 1'b0));
      chk(19'(ctl_q.hold), 19'h0_0000);
      $display("test counter hold done");
      // held and timed modes, without and with the extra gain step
      for (int i = 0; i < 4; i++) begin
         idx = 2'(i);
         fld = idx[1] ? 4'hf : 4'h0;
         len = 3 + 4 * int'(fld);
         put(2'h1, fw({idx[0], idx[1], 1'b1}, fld, 1'b0));
         put(2'h2, {1'b1, 13'h0094, 5'h0e});
         chk(19'(fb_q.go), 19'h0_0001);
         chk(19'(ctl_q.x4), 19'h0_0001);
         chk(19'(ctl_q.x16), 19'(idx[1]));
         chk(19'(boost_busy_q), 19'(idx[0]));
         pulse(len - 1);
         chk(19'(ctl_q.x4), 19'h0_0001);
         if (idx[0]) begin
            pulse(1);
            repeat (4) @(negedge clock);
            chk(19'(fb_q.go), 19'h0_0000);
         end else begin
            put(2'h2, {1'b0, 13'h0094, 5'h0e});
         end
         chk(19'(ctl_q.x4), 19'h0_0000);
         chk(19'(ctl_q.x16), 19'h0_0000);
         chk(19'(boost_busy_q), 19'h0_0000);
         $display("test boost mode %0d done", i);
      end
      put(2'h3, fw(3'h0, 4'h3, 1'b0));
      chk(19'(n_init), 19'h0_0001);
      chk(19'(n_tri > 0), 19'h0_0001);
      chk(func_q, fw(3'h0, 4'h3, 1'b0));
      put(2'h2, {1'b0, 13'h0094, 5'h0e});
      chk(19'(n_init), 19'h0_0001);
      put(2'h2, {1'b0, 13'h0094, 5'h0e});
      chk(19'(n_init), 19'h0_0000);
      $display("test initialization done");
      summarize();
   end

endmodule : ssd_top_bench
